// file: pkg/tsc_regs.svh
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// Byte offsets on the register bus
`define TSC_OFF_CTRL 8'h00
`define TSC_OFF_AUTONOMOUS_PAIR_SELECT 8'h04
`define TSC_OFF_PM0 8'h08
`define TSC_OFF_PM1 8'h0C
`define TSC_OFF_ATCFG 8'h10
`define TSC_OFF_PM2 8'h74
`define TSC_OFF_CMP3 8'h8C
`define TSC_OFF_CMP4 8'h90
`define TSC_OFF_CMP5 8'h94
`define TSC_OFF_CMP6 8'h98
`define TSC_OFF_CMP7 8'h9C
`define TSC_OFF_DMASTAT 8'hA0
`define TSC_OFF_SEQSTAT 8'hF0
`define TSC_OFF_PARAM 8'hF8
`define TSC_OFF_REV 8'hFC

// Field positions
`define TSC_CTRL_EN 0
`define TSC_CTRL_SOFT_RESET_TRIGGER 7
`define TSC_AT_EN 8
`define TSC_AT_IDX_HI 4
`define TSC_AT_IDX_LO 0
`define TSC_PM_HI 16
`define TSC_DIV_HI 31
`define TSC_DIV_LO 16
`define TSC_CHG_HI 15
`define TSC_CHG_LO 8
`define TSC_SET_HI 7
`define TSC_SET_LO 0

// Reset values
`define TSC_RST_WORD 32'h0000_0000
`define TSC_RST_PAIRS 17'h0_0000
`define TSC_RST_IDX 5'h00
`define TSC_RST_BYTE 8'h00
`define TSC_RST_DIV 16'h0000
`define TSC_RST_CNT17 17'h0_0000
`define TSC_ONE8 8'h01
`define TSC_ZERO8 8'h00

// Per-pair mode codes
`define TSC_MODE_OFF 3'h0
`define TSC_MODE_GRP_A 3'h1
`define TSC_MODE_GRP_B 3'h2
`define TSC_MODE_MATRIX 3'h3
`define TSC_MODE_DMA 3'h4

// Read-only identity words; values are arbitrary
`define TSC_PARAM_VAL 32'h0000_0011
`define TSC_REV_VAL 32'h0000_0100

`endif

// file: pkg/tsc_pkg.sv
package tsc_pkg;
    typedef enum logic [1:0] {
        TSC_IDLE = 2'b00,
        TSC_CHARGE = 2'b01,
        TSC_SETTLE = 2'b11
    } tsc_phase_e;
    typedef logic [16:0] tsc_pairs_t;
    typedef logic [31:0] tsc_word_t;
endpackage

// file: design/tsc_prescaler.sv
`timescale 1ns/100ps
`include "tsc_regs.svh"
module tsc_prescaler (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Control
    input wire logic enable,
    input wire logic [15:0] div,
    // Sample clock enable
    output logic tick
);
    import tsc_pkg::*;

    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    logic [16:0] last;

    // Period is 2*(div+1) core cycles
    assign last = {div, 1'b1};
    // A divider cut below the running count still wraps at once
    assign tick = enable && (cnt_q >= last);

    always_comb begin
        cnt_d = cnt_q;
        if (!enable || cnt_q >= last) begin
            cnt_d = `TSC_RST_CNT17;
        end else begin
            cnt_d = cnt_q + 17'h0_0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= `TSC_RST_CNT17;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// file: design/tsc_burst.sv
`timescale 1ns/100ps
`include "tsc_regs.svh"
module tsc_burst (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Control
    input wire logic run,
    input wire logic tick,
    input wire logic [7:0] charge_cycles,
    input wire logic [7:0] settle_cycles,
    // Phase outputs
    output logic charge_on,
    output logic settle_on,
    output logic cycle_done
);
    import tsc_pkg::*;

    tsc_phase_e phase_q;
    tsc_phase_e phase_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic done_q;
    logic done_d;
    logic [7:0] cnt_inc;

    assign cnt_inc = cnt_q + `TSC_ONE8;

    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        case (phase_q)
            TSC_IDLE: begin
                cnt_d = `TSC_ZERO8;
                if (run && tick) begin
                    if (charge_cycles != `TSC_ZERO8) begin
                        phase_d = TSC_CHARGE;
                    end else if (settle_cycles != `TSC_ZERO8) begin
                        phase_d = TSC_SETTLE;
                    end
                end
            end
            TSC_CHARGE: begin
                // Charge lasts charge_cycles sample ticks
                if (tick) begin
                    cnt_d = cnt_inc;
                    if (cnt_inc >= charge_cycles) begin
                        cnt_d = `TSC_ZERO8;
                        if (settle_cycles != `TSC_ZERO8) begin
                            phase_d = TSC_SETTLE;
                        end else begin
                            phase_d = TSC_IDLE;
                            done_d = 1'b1;
                        end
                    end
                end
            end
            TSC_SETTLE: begin
                // Settle waits settle_cycles ticks after the charge
                if (tick) begin
                    cnt_d = cnt_inc;
                    if (cnt_inc >= settle_cycles) begin
                        cnt_d = `TSC_ZERO8;
                        phase_d = TSC_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            default: begin
                phase_d = TSC_IDLE;
                cnt_d = `TSC_ZERO8;
            end
        endcase
        if (!run) begin
            phase_d = TSC_IDLE;
            cnt_d = `TSC_ZERO8;
            done_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= TSC_IDLE;
            cnt_q <= `TSC_ZERO8;
            done_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign charge_on = (phase_q == TSC_CHARGE);
    assign settle_on = (phase_q == TSC_SETTLE);
    assign cycle_done = done_q;
endmodule

// file: design/tsc_top.sv
`timescale 1ns/100ps
`include "tsc_regs.svh"
module tsc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output tsc_pkg::tsc_word_t hrdata,
    // Module state
    output logic module_enable,
    output logic sample_tick,
    // Pair group assignment
    output tsc_pkg::tsc_pairs_t pair_group_a,
    output tsc_pkg::tsc_pairs_t pair_group_b,
    output tsc_pkg::tsc_pairs_t pair_group_matrix,
    output tsc_pkg::tsc_pairs_t pair_group_dma,
    // Autonomous sensor
    output tsc_pkg::tsc_pairs_t sense_line_a,
    output tsc_pkg::tsc_pairs_t sense_line_b,
    output logic auto_charge,
    output logic auto_settle,
    output logic auto_cycle_done,
    // DMA-driven sensors
    output logic dma_charge,
    output logic dma_settle,
    output logic dma_cycle_done
);
    import tsc_pkg::*;

    // Register state
    logic en_q;
    logic en_d;
    logic autonomous_sense_enable_q;
    logic autonomous_sense_enable_d;
    logic [4:0] idx_q;
    logic [4:0] idx_d;
    tsc_pairs_t pm0_q;
    tsc_pairs_t pm0_d;
    tsc_pairs_t pm1_q;
    tsc_pairs_t pm1_d;
    tsc_pairs_t pm2_q;
    tsc_pairs_t pm2_d;
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic [7:0] chg_q;
    logic [7:0] chg_d;
    logic [7:0] set_q;
    logic [7:0] set_d;
    tsc_word_t cmp_q [3:7];
    tsc_word_t cmp_d [3:7];

    // Bus state
    logic wr_pend_q;
    logic wr_pend_d;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_addr_d;
    tsc_word_t rdata_q;
    tsc_word_t rdata_d;

    // Decoded group state, registered for the outputs
    tsc_pairs_t grp_a_c;
    tsc_pairs_t grp_b_c;
    tsc_pairs_t grp_m_c;
    tsc_pairs_t grp_d_c;
    tsc_pairs_t line_c;
    tsc_pairs_t grp_a_q;
    tsc_pairs_t grp_b_q;
    tsc_pairs_t grp_m_q;
    tsc_pairs_t grp_d_q;
    tsc_pairs_t line_q;

    logic addr_take;
    logic [7:0] addr_lo;
    logic auto_run;
    logic dma_run;
    logic soft_reset_trigger;
    logic a_charge;
    logic a_settle;
    logic d_charge;
    logic d_settle;
    tsc_word_t seq_status;

    // Zero-wait slave: every transfer ends in one data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign addr_take = hsel && hready && htrans[1];
    assign addr_lo = {haddr[7:2], 2'b00};

    // Software reset acts in the write data phase
    assign soft_reset_trigger = wr_pend_q && (wr_addr_q == `TSC_OFF_CTRL) &&
                   hwdata[`TSC_CTRL_SOFT_RESET_TRIGGER];

    assign auto_run = en_q && autonomous_sense_enable_q;
    assign dma_run = en_q && (|grp_d_q);

    assign seq_status = {26'h000_0000, d_settle, d_charge,
                         a_settle, a_charge, autonomous_sense_enable_q, en_q};

    // Per-pair decode of the three mode planes
    genvar gi;
    generate
        for (gi = 0; gi <= `TSC_PM_HI; gi = gi + 1) begin : g_pair
            logic [2:0] code;
            assign code = {pm2_q[gi], pm1_q[gi], pm0_q[gi]};
            assign grp_a_c[gi] = en_q && (code == `TSC_MODE_GRP_A);
            assign grp_b_c[gi] = en_q && (code == `TSC_MODE_GRP_B);
            assign grp_m_c[gi] = en_q && (code == `TSC_MODE_MATRIX);
            assign grp_d_c[gi] = en_q && (code == `TSC_MODE_DMA);
            // Index beyond the last pair selects no line at all
            assign line_c[gi] = auto_run &&
                                (idx_q == 5'(gi));
        end
    endgenerate

    // Read mux, sampled in the address phase
    always_comb begin
        rdata_d = rdata_q;
        if (addr_take && !hwrite) begin
            case (addr_lo)
                `TSC_OFF_CTRL: begin
                    // Reset trigger bit never reads back
                    rdata_d = {31'h0000_0000, en_q};
                end
                `TSC_OFF_AUTONOMOUS_PAIR_SELECT: begin
                    rdata_d = {23'h00_0000, autonomous_sense_enable_q, 3'h0, idx_q};
                end
                `TSC_OFF_PM0: begin
                    rdata_d = {15'h0000, pm0_q};
                end
                `TSC_OFF_PM1: begin
                    rdata_d = {15'h0000, pm1_q};
                end
                `TSC_OFF_PM2: begin
                    rdata_d = {15'h0000, pm2_q};
                end
                `TSC_OFF_ATCFG: begin
                    rdata_d = {div_q, chg_q, set_q};
                end
                `TSC_OFF_CMP3: begin
                    rdata_d = cmp_q[3];
                end
                `TSC_OFF_CMP4: begin
                    rdata_d = cmp_q[4];
                end
                `TSC_OFF_CMP5: begin
                    rdata_d = cmp_q[5];
                end
                `TSC_OFF_CMP6: begin
                    rdata_d = cmp_q[6];
                end
                `TSC_OFF_CMP7: begin
                    rdata_d = cmp_q[7];
                end
                `TSC_OFF_SEQSTAT: begin
                    rdata_d = seq_status;
                end
                `TSC_OFF_PARAM: begin
                    rdata_d = `TSC_PARAM_VAL;
                end
                `TSC_OFF_REV: begin
                    rdata_d = `TSC_REV_VAL;
                end
                default: begin
                    // Unmapped and status words with no contents read zero
                    rdata_d = `TSC_RST_WORD;
                end
            endcase
        end
    end

    // Register writes, taken in the data phase
    always_comb begin
        wr_pend_d = addr_take && hwrite;
        wr_addr_d = addr_take ? addr_lo : wr_addr_q;
        en_d = en_q;
        autonomous_sense_enable_d = autonomous_sense_enable_q;
        idx_d = idx_q;
        pm0_d = pm0_q;
        pm1_d = pm1_q;
        pm2_d = pm2_q;
        div_d = div_q;
        chg_d = chg_q;
        set_d = set_q;
        for (int i = 3; i <= 7; i++) begin
            cmp_d[i] = cmp_q[i];
        end
        if (wr_pend_q) begin
            // Writes to read-only words fall through untouched
            case (wr_addr_q)
                `TSC_OFF_CTRL: begin
                    en_d = hwdata[`TSC_CTRL_EN];
                end
                `TSC_OFF_AUTONOMOUS_PAIR_SELECT: begin
                    autonomous_sense_enable_d = hwdata[`TSC_AT_EN];
                    idx_d = hwdata[`TSC_AT_IDX_HI:`TSC_AT_IDX_LO];
                end
                `TSC_OFF_PM0: begin
                    pm0_d = hwdata[`TSC_PM_HI:0];
                end
                `TSC_OFF_PM1: begin
                    pm1_d = hwdata[`TSC_PM_HI:0];
                end
                `TSC_OFF_PM2: begin
                    pm2_d = hwdata[`TSC_PM_HI:0];
                end
                `TSC_OFF_ATCFG: begin
                    div_d = hwdata[`TSC_DIV_HI:`TSC_DIV_LO];
                    chg_d = hwdata[`TSC_CHG_HI:`TSC_CHG_LO];
                    set_d = hwdata[`TSC_SET_HI:`TSC_SET_LO];
                end
                `TSC_OFF_CMP3: begin
                    cmp_d[3] = hwdata;
                end
                `TSC_OFF_CMP4: begin
                    cmp_d[4] = hwdata;
                end
                `TSC_OFF_CMP5: begin
                    cmp_d[5] = hwdata;
                end
                `TSC_OFF_CMP6: begin
                    cmp_d[6] = hwdata;
                end
                `TSC_OFF_CMP7: begin
                    cmp_d[7] = hwdata;
                end
                default: begin
                end
            endcase
        end
        if (soft_reset_trigger) begin
            // Whole register file back to reset, module left disabled
            en_d = 1'b0;
            autonomous_sense_enable_d = 1'b0;
            idx_d = `TSC_RST_IDX;
            pm0_d = `TSC_RST_PAIRS;
            pm1_d = `TSC_RST_PAIRS;
            pm2_d = `TSC_RST_PAIRS;
            div_d = `TSC_RST_DIV;
            chg_d = `TSC_RST_BYTE;
            set_d = `TSC_RST_BYTE;
            for (int i = 3; i <= 7; i++) begin
                cmp_d[i] = `TSC_RST_WORD;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= `TSC_OFF_CTRL;
            rdata_q <= `TSC_RST_WORD;
            en_q <= 1'b0;
            autonomous_sense_enable_q <= 1'b0;
            idx_q <= `TSC_RST_IDX;
            pm0_q <= `TSC_RST_PAIRS;
            pm1_q <= `TSC_RST_PAIRS;
            pm2_q <= `TSC_RST_PAIRS;
            div_q <= `TSC_RST_DIV;
            chg_q <= `TSC_RST_BYTE;
            set_q <= `TSC_RST_BYTE;
            for (int i = 3; i <= 7; i++) begin
                cmp_q[i] <= `TSC_RST_WORD;
            end
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
            en_q <= en_d;
            autonomous_sense_enable_q <= autonomous_sense_enable_d;
            idx_q <= idx_d;
            pm0_q <= pm0_d;
            pm1_q <= pm1_d;
            pm2_q <= pm2_d;
            div_q <= div_d;
            chg_q <= chg_d;
            set_q <= set_d;
            for (int i = 3; i <= 7; i++) begin
                cmp_q[i] <= cmp_d[i];
            end
        end
    end

    // Output flops for decoded groups and line selects
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            grp_a_q <= `TSC_RST_PAIRS;
            grp_b_q <= `TSC_RST_PAIRS;
            grp_m_q <= `TSC_RST_PAIRS;
            grp_d_q <= `TSC_RST_PAIRS;
            line_q <= `TSC_RST_PAIRS;
        end else begin
            grp_a_q <= grp_a_c;
            grp_b_q <= grp_b_c;
            grp_m_q <= grp_m_c;
            grp_d_q <= grp_d_c;
            line_q <= line_c;
        end
    end

    assign module_enable = en_q;
    assign pair_group_a = grp_a_q;
    assign pair_group_b = grp_b_q;
    assign pair_group_matrix = grp_m_q;
    assign pair_group_dma = grp_d_q;
    assign sense_line_a = line_q;
    assign sense_line_b = line_q;

    // Sample clock enable; held in reset while the module is off
    tsc_prescaler u_presc (
        .core_clk(core_clk),
        .rstn(rstn),
        .enable(en_q),
        .div(div_q),
        .tick(sample_tick)
    );

    tsc_burst u_auto (
        .core_clk(core_clk),
        .rstn(rstn),
        .run(auto_run),
        .tick(sample_tick),
        .charge_cycles(chg_q),
        .settle_cycles(set_q),
        .charge_on(a_charge),
        .settle_on(a_settle),
        .cycle_done(auto_cycle_done)
    );

    tsc_burst u_dma (
        .core_clk(core_clk),
        .rstn(rstn),
        .run(dma_run),
        .tick(sample_tick),
        .charge_cycles(chg_q),
        .settle_cycles(set_q),
        .charge_on(d_charge),
        .settle_on(d_settle),
        .cycle_done(dma_cycle_done)
    );

    assign auto_charge = a_charge;
    assign auto_settle = a_settle;
    assign dma_charge = d_charge;
    assign dma_settle = d_settle;
endmodule

// file: tb/tsc_top_props.sv
`timescale 1ns/100ps
`include "tsc_regs.svh"
module tsc_top_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire tsc_pkg::tsc_word_t hrdata,
    // Module outputs
    input wire logic module_enable,
    input wire logic sample_tick,
    input wire tsc_pkg::tsc_pairs_t pair_group_a,
    input wire tsc_pkg::tsc_pairs_t pair_group_b,
    input wire tsc_pkg::tsc_pairs_t pair_group_matrix,
    input wire tsc_pkg::tsc_pairs_t pair_group_dma,
    input wire tsc_pkg::tsc_pairs_t sense_line_a,
    input wire tsc_pkg::tsc_pairs_t sense_line_b,
    input wire logic auto_charge,
    input wire logic auto_settle,
    input wire logic auto_cycle_done
);
    import tsc_pkg::*;
    logic taken, wr_q, rd_q, wr_d, rd_d;
    logic [7:0] adr_q, adr_d;
    assign taken = hsel && hready && htrans[1];
    always_comb begin
        wr_d = taken && hwrite;
        rd_d = taken && !hwrite;
        adr_d = {haddr[7:2], 2'b00};
    end
    // Data phase tracking mirrors the slave's one-cycle answer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            adr_q <= 8'h00;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            adr_q <= adr_d;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    soft_reset_trigger_clear_a: assert property (
        wr_q && adr_q == `TSC_OFF_CTRL && hwdata[7] |=> !module_enable)
        else $error("soft reset left module enabled");
    soft_reset_trigger_read_a: assert property (
        rd_q && adr_q == `TSC_OFF_CTRL |-> hrdata[31:1] == 31'h0000_0000)
        else $error("control read shows nonzero upper bits");
    en_write_a: assert property (
        wr_q && adr_q == `TSC_OFF_CTRL && !hwdata[7]
        |=> module_enable == $past(hwdata[0]))
        else $error("enable bit not taken from write");
    param_word_a: assert property (
        rd_q && adr_q == `TSC_OFF_PARAM |-> hrdata == `TSC_PARAM_VAL)
        else $error("parameter word wrong");
    lines_match_a: assert property (
        sense_line_a == sense_line_b && $onehot0(sense_line_a))
        else $error("sense lines not one matching pair");
    idle_zero_a: assert property (
        !module_enable ##1 !module_enable |-> sense_line_a == '0 &&
        (pair_group_a | pair_group_b | pair_group_dma) == '0)
        else $error("disabled module drives pairs");
    groups_excl_a: assert property (
        ((pair_group_a & pair_group_b) |
        (pair_group_matrix & pair_group_dma) |
        ((pair_group_a | pair_group_b) &
        (pair_group_matrix | pair_group_dma))) == '0)
        else $error("pair in two groups");
    tick_pulse_a: assert property (
        sample_tick |=> !sample_tick)
        else $error("sample tick longer than one cycle");
    phase_excl_a: assert property (
        !(auto_charge && auto_settle) &&
        !(auto_cycle_done && (auto_charge || auto_settle)))
        else $error("autonomous phases overlap");
    auto_gate_a: assert property (
        auto_charge || auto_settle |-> module_enable || $past(module_enable))
        else $error("autonomous sensor runs while disabled");
    cover property (wr_q && adr_q == `TSC_OFF_CTRL && hwdata[7]);
    cover property (auto_cycle_done);
    cover property ($rose(auto_settle));
endmodule
bind tsc_top tsc_top_props u_props (.core_clk(core_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .module_enable(module_enable), .sample_tick(sample_tick),
    .pair_group_a(pair_group_a), .pair_group_b(pair_group_b),
    .pair_group_matrix(pair_group_matrix),
    .pair_group_dma(pair_group_dma), .sense_line_a(sense_line_a),
    .sense_line_b(sense_line_b), .auto_charge(auto_charge),
    .auto_settle(auto_settle), .auto_cycle_done(auto_cycle_done));

// file: tb/tsc_top_test.sv
`timescale 1ns/100ps
`include "tsc_regs.svh"
module tsc_top_test;
    import tsc_pkg::*;
    logic core_clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    tsc_word_t hrdata;
    tsc_pairs_t grp_a, grp_b, grp_m, grp_d, line_a, line_b;
    logic module_enable, sample_tick, a_chg, a_set, a_done;
    logic d_chg, d_set, d_done;
    logic [4:0] mon;
    int fail_count, check_count, cycles;
    assign hready = hreadyout;
    assign mon = {sample_tick, d_set, d_chg, a_set, a_chg};
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    tsc_top DUT (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .module_enable(module_enable),
        .sample_tick(sample_tick), .pair_group_a(grp_a),
        .pair_group_b(grp_b), .pair_group_matrix(grp_m),
        .pair_group_dma(grp_d), .sense_line_a(line_a),
        .sense_line_b(line_b), .auto_charge(a_chg), .auto_settle(a_set),
        .auto_cycle_done(a_done), .dma_charge(d_chg), .dma_settle(d_set),
        .dma_cycle_done(d_done));
    task end_of_test;
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task chk(input string name, input tsc_word_t exp, input tsc_word_t got);
        check_count++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Address phase, then data phase; read data taken at the closing edge
    task bus(input logic w, input logic [7:0] a, input tsc_word_t wd,
             output tsc_word_t rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        chk("hresp", 32'h0, {31'h0, hresp});
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input tsc_word_t d);
        tsc_word_t x;
        bus(1'b1, a, d, x);
    endtask
    task rdc(input logic [7:0] a, input tsc_word_t exp);
        tsc_word_t x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk($sformatf("reg_%h", a), exp, x);
    endtask
    // Starts at a transition so a partial run is never counted
    task run_len(input int s, input logic v, output int len);
        int n;
        n = 0;
        while (mon[s] === v && n < 500) begin cyc(1); n++; end
        while (mon[s] !== v && n < 1000) begin cyc(1); n++; end
        len = 0;
        while (mon[s] === v && len < 500) begin cyc(1); len++; end
    endtask
    logic [7:0] zoffs [11] = '{`TSC_OFF_CTRL, `TSC_OFF_AUTONOMOUS_PAIR_SELECT, `TSC_OFF_PM0,
        `TSC_OFF_PM1, `TSC_OFF_ATCFG, `TSC_OFF_PM2, `TSC_OFF_CMP3,
        `TSC_OFF_CMP7, `TSC_OFF_DMASTAT, 8'h14, 8'h3C};
    logic [7:0] pms [3] = '{`TSC_OFF_PM0, `TSC_OFF_PM1, `TSC_OFF_PM2};
    task t_reset;
        foreach (zoffs[i]) rdc(zoffs[i], 32'h0000_0000);
        rdc(`TSC_OFF_PARAM, `TSC_PARAM_VAL);
        rdc(`TSC_OFF_REV, `TSC_REV_VAL);
    endtask
    task t_rw;
        wr(`TSC_OFF_CTRL, 32'hFFFF_FF7F);
        rdc(`TSC_OFF_CTRL, 32'h0000_0001);
        chk("module_enable", 32'h1, {31'h0, module_enable});
        wr(`TSC_OFF_AUTONOMOUS_PAIR_SELECT, 32'hFFFF_FFFF);
        rdc(`TSC_OFF_AUTONOMOUS_PAIR_SELECT, 32'h0000_011F);
        rdc(`TSC_OFF_SEQSTAT, 32'h0000_0003);
        foreach (pms[i]) begin
            wr(pms[i], 32'hFFFF_FFFF);
            rdc(pms[i], 32'h0001_FFFF);
        end
        wr(`TSC_OFF_CMP5, 32'hA5C3_0F96);
        rdc(`TSC_OFF_CMP5, 32'hA5C3_0F96);
        wr(`TSC_OFF_PARAM, 32'h0000_0000);
        wr(`TSC_OFF_REV, 32'hFFFF_FFFF);
        wr(`TSC_OFF_DMASTAT, 32'hFFFF_FFFF);
        rdc(`TSC_OFF_PARAM, `TSC_PARAM_VAL);
        rdc(`TSC_OFF_REV, `TSC_REV_VAL);
        rdc(`TSC_OFF_DMASTAT, 32'h0000_0000);
        wr(`TSC_OFF_AUTONOMOUS_PAIR_SELECT, 32'h0000_0000);
    endtask
    task t_modes;
        tsc_pairs_t p0, p1, p2, ea, eb, em, ed;
        logic [2:0] c;
        for (int n = 0; n < 17; n++) begin
            c = n[2:0];
            {p2[n], p1[n], p0[n]} = c;
            ea[n] = (c == `TSC_MODE_GRP_A);
            eb[n] = (c == `TSC_MODE_GRP_B);
            em[n] = (c == `TSC_MODE_MATRIX);
            ed[n] = (c == `TSC_MODE_DMA);
        end
        wr(`TSC_OFF_PM0, {15'h0000, p0});
        wr(`TSC_OFF_PM1, {15'h0000, p1});
        wr(`TSC_OFF_PM2, {15'h0000, p2});
        cyc(3);
        chk("grp_a", {15'h0000, ea}, {15'h0000, grp_a});
        chk("grp_b", {15'h0000, eb}, {15'h0000, grp_b});
        chk("grp_m", {15'h0000, em}, {15'h0000, grp_m});
        chk("grp_d", {15'h0000, ed}, {15'h0000, grp_d});
    endtask
    task t_lines;
        static int idx [3] = '{0, 16, 17};
        tsc_pairs_t e;
        foreach (idx[i]) begin
            wr(`TSC_OFF_AUTONOMOUS_PAIR_SELECT, 32'h0000_0100 | idx[i]);
            cyc(3);
            e = (idx[i] < 17) ? (17'h0_0001 << idx[i]) : 17'h0_0000;
            chk("line_a", {15'h0000, e}, {15'h0000, line_a});
            chk("line_b", {15'h0000, e}, {15'h0000, line_b});
        end
    endtask
    task t_timing;
        int len;
        logic busy;
        wr(`TSC_OFF_ATCFG, 32'h0002_0000);
        run_len(4, 1'b0, len);
        chk("tick_gap", 32'h0000_0005, len);
        // Lengths counted in core cycles: two per tick at divider zero
        wr(`TSC_OFF_ATCFG, 32'h0000_0302);
        wr(`TSC_OFF_AUTONOMOUS_PAIR_SELECT, 32'h0000_0105);
        run_len(0, 1'b1, len);
        chk("auto_charge", 32'h0000_0006, len);
        run_len(1, 1'b1, len);
        chk("auto_settle", 32'h0000_0004, len);
        chk("auto_done", 32'h1, {31'h0, a_done});
        run_len(2, 1'b1, len);
        chk("dma_charge", 32'h0000_0006, len);
        run_len(3, 1'b1, len);
        chk("dma_settle", 32'h0000_0004, len);
        chk("dma_done", 32'h1, {31'h0, d_done});
        wr(`TSC_OFF_AUTONOMOUS_PAIR_SELECT, 32'h0000_0005);
        cyc(2);
        busy = 1'b0;
        repeat (30) begin cyc(1); busy = busy | a_chg | a_set; end
        chk("auto_idle", 32'h0, {31'h0, busy});
        chk("line_off", 32'h0, {15'h0000, line_a});
    endtask
    task t_soft_reset_trigger;
        wr(`TSC_OFF_CTRL, 32'h0000_0000);
        cyc(3);
        chk("grp_d_off", 32'h0, {15'h0000, grp_d});
        rdc(`TSC_OFF_ATCFG, 32'h0000_0302);
        wr(`TSC_OFF_AUTONOMOUS_PAIR_SELECT, 32'h0000_0103);
        wr(`TSC_OFF_CTRL, 32'h0000_0001);
        wr(`TSC_OFF_CMP3, 32'h1234_5678);
        cyc(4);
        wr(`TSC_OFF_CTRL, 32'h0000_0081);
        cyc(3);
        chk("soft_reset_trigger_en", 32'h0, {31'h0, module_enable});
        chk("soft_reset_trigger_dma", 32'h0, {31'h0, d_chg | d_set});
        foreach (zoffs[i]) rdc(zoffs[i], 32'h0000_0000);
    endtask
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_rw();
        t_modes();
        t_lines();
        t_timing();
        t_soft_reset_trigger();
        end_of_test();
    end
endmodule
